/* scm_pkg.sv */
/*
  package for the system clock and power mode controller: register offsets,
  field positions, reset values, mode enumeration, timing counts.
  assumes a single 250 MHz clock domain.
*/
`default_nettype none

package scm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] OFF_SYS_CLK_CTRL = 4'h0;
  localparam logic [3:0] OFF_FAST_OSC_CTRL = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_WDT_CTRL = 4'h3;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SEL_LSB = 5;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam int FAST_EN_BIT = 0;
  localparam int FAST_STABLE_BIT = 1;
  localparam int PWR_DOWN_BIT = 0;
  localparam int TOF_BIT = 1;
  localparam int WDT_EN_BIT = 0;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic FAST_EN_RESET = 1'b1;
  localparam logic WDT_EN_RESET = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAST_STARTUP_NS = 1000;
  localparam int FAST_STARTUP_CYC = (FAST_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_STARTUP_CYC = 8;
  localparam int CNT_W = 9;
  localparam int DIV_W = 6;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_IDLE_SLOW_ONLY,
    MODE_IDLE_BOTH_CLOCKS,
    MODE_IDLE_FAST_ONLY
  } scm_mode_t;

endpackage

`default_nettype wire

/* scm_sysclk_mode_control.sv */
/*
  system clock select, fast oscillator enable and stability, halt into sleep or
  idle modes. assumes the core gives one-cycle halt and register strobes and
  outside logic gives a wake level; oscillators themselves are modelled by
  enables and counted start-up times, divided clock phases as enables.
*/
`default_nettype none

// What this block does
// - select field picks divided fast or slow
// - fast keep bit holds fast osc in halt
// - slow keep bit holds slow osc in halt
// - unused control bits zero, fields reset zero
// - fast osc enable, resets to one
// - stable flag clears on enable, sets later
// - slow switch completes once slow stable
// - both keeps zero: sleep, all stop except slow osc while watchdog enabled
// - fast off slow on: idle slow only
// - both keeps one: idle both clocks
// - fast on slow off: idle fast only
// - halt keeps memory, registers, ports unchanged
// - halt sets power down, clears timeout
// - halt clears watchdog, resumes if enabled
// - fast 8MHz source, slow 32kHz feeds watchdog
// - sleep keeps slow clock only for watchdog
module scm_sysclk_mode_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // core and wake
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic wdt_timeout_i,
  // clock enables and status
  output logic sys_clk_en_o,
  output logic fast_osc_run_o,
  output logic slow_osc_run_o,
  output logic wdt_clear_o,
  output logic cpu_stopped_o,
  output logic [2:0] mode_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] sel_act;
    logic fast_keep;
    logic slow_keep;
    logic fast_en;
    logic fast_stable;
    logic [scm_pkg::CNT_W-1:0] fast_cnt;
    logic slow_stable;
    logic [scm_pkg::CNT_W-1:0] slow_cnt;
    logic pwr_down;
    logic tof;
    logic wdt_en;
    logic [scm_pkg::DIV_W-1:0] div;
    scm_pkg::scm_mode_t mode;
    logic [7:0] rdata;
    logic sys_en;
    logic fast_run;
    logic slow_run;
    logic wdt_clr;
    logic stopped;
  } scm_state_t;

  scm_state_t st_ff;
  scm_state_t nxt_st;

  localparam logic [scm_pkg::CNT_W-1:0] FAST_CNT_MAX =
    scm_pkg::CNT_W'(scm_pkg::FAST_STARTUP_CYC);
  localparam logic [scm_pkg::CNT_W-1:0] SLOW_CNT_MAX =
    scm_pkg::CNT_W'(scm_pkg::SLOW_STARTUP_CYC);

  logic halted;
  logic slow_sel_act;
  logic phase_end;
  logic fast_want;
  logic slow_want;
  logic [scm_pkg::DIV_W-1:0] div_mask;

  always_comb begin
    halted = (st_ff.mode != scm_pkg::MODE_RUN);
    slow_sel_act = (st_ff.sel_act == scm_pkg::SEL_SLOW);
    // divide by 2**sel: mask low sel bits of the free counter
    div_mask = scm_pkg::DIV_W'((7'h01 << st_ff.sel_act) - 7'h01);
    phase_end = ((st_ff.div & div_mask) == div_mask);
    nxt_st = st_ff;
    nxt_st.wdt_clr = 1'b0;
    nxt_st.div = st_ff.div + scm_pkg::DIV_W'(1);

    // ****************************************
    // register writes
    // ****************************************
    if (wr_i && !halted) begin
      case (addr_i)
        scm_pkg::OFF_SYS_CLK_CTRL: begin
          nxt_st.sel = wdata_i[scm_pkg::SEL_LSB +: 3];
          nxt_st.fast_keep = wdata_i[scm_pkg::FAST_KEEP_BIT];
          nxt_st.slow_keep = wdata_i[scm_pkg::SLOW_KEEP_BIT];
        end
        scm_pkg::OFF_FAST_OSC_CTRL: begin
          nxt_st.fast_en = wdata_i[scm_pkg::FAST_EN_BIT];
          if (wdata_i[scm_pkg::FAST_EN_BIT] && !st_ff.fast_en) begin
            nxt_st.fast_stable = 1'b0;
            nxt_st.fast_cnt = '0;
          end
        end
        scm_pkg::OFF_STATUS: begin
          // software clear only; a same-cycle timeout below still wins
          if (!wdata_i[scm_pkg::PWR_DOWN_BIT]) nxt_st.pwr_down = 1'b0;
          if (!wdata_i[scm_pkg::TOF_BIT]) nxt_st.tof = 1'b0;
        end
        scm_pkg::OFF_WDT_CTRL: begin
          nxt_st.wdt_en = wdata_i[scm_pkg::WDT_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // halt entry and wake
    // ****************************************
    case (st_ff.mode)
      scm_pkg::MODE_RUN: begin
        if (halt_i) begin
          case ({st_ff.fast_keep, st_ff.slow_keep})
            2'b00: nxt_st.mode = scm_pkg::MODE_SLEEP;
            2'b01: nxt_st.mode = scm_pkg::MODE_IDLE_SLOW_ONLY;
            2'b11: nxt_st.mode = scm_pkg::MODE_IDLE_BOTH_CLOCKS;
            default: nxt_st.mode = scm_pkg::MODE_IDLE_FAST_ONLY;
          endcase
          nxt_st.pwr_down = 1'b1;
          nxt_st.tof = 1'b0;
          nxt_st.wdt_clr = 1'b1;
        end
      end
      default: begin
        // register writes are blocked while halted
        if (wake_i) nxt_st.mode = scm_pkg::MODE_RUN;
      end
    endcase
    if (wdt_timeout_i) nxt_st.tof = 1'b1;
    nxt_st.stopped = (nxt_st.mode != scm_pkg::MODE_RUN);

    // ****************************************
    // oscillator enables and stability
    // ****************************************
    fast_want = st_ff.fast_en && (!halted || st_ff.fast_keep);
    // watchdog keeps the slow source alive in sleep
    slow_want = !halted || st_ff.slow_keep || st_ff.wdt_en;
    if (!fast_want) begin
      nxt_st.fast_stable = 1'b0;
      nxt_st.fast_cnt = '0;
    end else if (st_ff.fast_cnt == FAST_CNT_MAX) begin
      nxt_st.fast_stable = 1'b1;
    end else begin
      nxt_st.fast_cnt = st_ff.fast_cnt + scm_pkg::CNT_W'(1);
    end
    if (!slow_want) begin
      nxt_st.slow_stable = 1'b0;
      nxt_st.slow_cnt = '0;
    end else if (st_ff.slow_cnt == SLOW_CNT_MAX) begin
      nxt_st.slow_stable = 1'b1;
    end else begin
      nxt_st.slow_cnt = st_ff.slow_cnt + scm_pkg::CNT_W'(1);
    end
    nxt_st.fast_run = fast_want;
    nxt_st.slow_run = slow_want;

    // ****************************************
    // glitch-free select change
    // ****************************************
    // change only at the end of a whole divided phase, never mid-period
    if (st_ff.sel != st_ff.sel_act && phase_end) begin
      if (st_ff.sel == scm_pkg::SEL_SLOW) begin
        if (st_ff.slow_stable) nxt_st.sel_act = st_ff.sel;
      end else begin
        nxt_st.sel_act = st_ff.sel;
      end
      nxt_st.div = '0;
    end
    // system clock enable: slow stable level stands for slow source edges
    nxt_st.sys_en = !halted && (slow_sel_act ? st_ff.slow_stable : phase_end);

    // ****************************************
    // read data, one cycle later
    // ****************************************
    nxt_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        scm_pkg::OFF_SYS_CLK_CTRL: begin
          nxt_st.rdata = {st_ff.sel, 3'h0, st_ff.fast_keep, st_ff.slow_keep};
        end
        scm_pkg::OFF_FAST_OSC_CTRL: begin
          nxt_st.rdata = {6'h00, st_ff.fast_stable, st_ff.fast_en};
        end
        scm_pkg::OFF_STATUS: begin
          nxt_st.rdata = {6'h00, st_ff.tof, st_ff.pwr_down};
        end
        scm_pkg::OFF_WDT_CTRL: begin
          nxt_st.rdata = {7'h00, st_ff.wdt_en};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.sel <= scm_pkg::SEL_RESET;
      st_ff.sel_act <= scm_pkg::SEL_RESET;
      st_ff.fast_en <= scm_pkg::FAST_EN_RESET;
      st_ff.wdt_en <= scm_pkg::WDT_EN_RESET;
      st_ff.mode <= scm_pkg::MODE_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign sys_clk_en_o = st_ff.sys_en;
  assign fast_osc_run_o = st_ff.fast_run;
  assign slow_osc_run_o = st_ff.slow_run;
  assign wdt_clear_o = st_ff.wdt_clr;
  assign cpu_stopped_o = st_ff.stopped;
  assign mode_o = st_ff.mode;

  // ****************************************
  // checks
  // ****************************************
  property p_sleep_entry;
    @(posedge clk_i) disable iff (reset_i)
      (!halted && halt_i && !st_ff.fast_keep && !st_ff.slow_keep)
        |=> (st_ff.mode == scm_pkg::MODE_SLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep");

  property p_idle_slow;
    @(posedge clk_i) disable iff (reset_i)
      (!halted && halt_i && !st_ff.fast_keep && st_ff.slow_keep)
        |=> (st_ff.mode == scm_pkg::MODE_IDLE_SLOW_ONLY) ##1 slow_osc_run_o && !fast_osc_run_o;
  endproperty
  a_idle_slow: assert property (p_idle_slow) else $error("bad idle slow");

  property p_idle_both;
    @(posedge clk_i) disable iff (reset_i)
      (!halted && halt_i && st_ff.fast_keep && st_ff.slow_keep)
        |=> (st_ff.mode == scm_pkg::MODE_IDLE_BOTH_CLOCKS);
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("bad idle both");

  property p_idle_fast;
    @(posedge clk_i) disable iff (reset_i)
      (!halted && halt_i && st_ff.fast_keep && !st_ff.slow_keep)
        |=> (st_ff.mode == scm_pkg::MODE_IDLE_FAST_ONLY);
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("bad idle fast");

  property p_flags;
    @(posedge clk_i) disable iff (reset_i)
      (!halted && halt_i && !wdt_timeout_i) |=> st_ff.pwr_down && !st_ff.tof && wdt_clear_o;
  endproperty
  a_flags: assert property (p_flags) else $error("halt flags wrong");

  property p_stable_clear;
    @(posedge clk_i) disable iff (reset_i)
      (wr_i && !halted && addr_i == scm_pkg::OFF_FAST_OSC_CTRL && wdata_i[0] && !st_ff.fast_en)
        |=> !st_ff.fast_stable ##1 !st_ff.fast_stable;
  endproperty
  a_stable_clear: assert property (p_stable_clear) else $error("stable not cleared");

  property p_slow_switch;
    @(posedge clk_i) disable iff (reset_i)
      $changed(st_ff.sel_act) && st_ff.sel_act == scm_pkg::SEL_SLOW |-> $past(st_ff.slow_stable);
  endproperty
  a_slow_switch: assert property (p_slow_switch) else $error("switched to unstable slow");

  property p_halt_regs;
    @(posedge clk_i) disable iff (reset_i)
      halted && !wake_i |=> $stable(st_ff.sel) && $stable(st_ff.fast_en);
  endproperty
  a_halt_regs: assert property (p_halt_regs) else $error("registers changed in halt");

  property p_no_clk_halt;
    @(posedge clk_i) disable iff (reset_i)
      halted |=> !sys_clk_en_o;
  endproperty
  a_no_clk_halt: assert property (p_no_clk_halt) else $error("clock in halt");

  property p_read_ctrl;
    @(posedge clk_i) disable iff (reset_i)
      rd_i && addr_i == scm_pkg::OFF_SYS_CLK_CTRL |=> rdata_o[4:2] == 3'h0;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("reserved bits set");

  property p_read_fast;
    @(posedge clk_i) disable iff (reset_i)
      rd_i && addr_i == scm_pkg::OFF_FAST_OSC_CTRL |=> rdata_o[7:2] == 6'h00;
  endproperty
  a_read_fast: assert property (p_read_fast) else $error("fast ctrl upper bits set");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (reset_i)
      !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_stable_wait;
    @(posedge clk_i) disable iff (reset_i)
      $rose(st_ff.fast_stable) |-> st_ff.fast_cnt == FAST_CNT_MAX;
  endproperty
  a_stable_wait: assert property (p_stable_wait) else $error("stable before start-up");

  property p_fast_off_halt;
    @(posedge clk_i) disable iff (reset_i)
      halted && !st_ff.fast_keep |=> !fast_osc_run_o;
  endproperty
  a_fast_off_halt: assert property (p_fast_off_halt) else $error("fast osc kept in halt");

  property p_slow_sleep;
    @(posedge clk_i) disable iff (reset_i)
      st_ff.mode == scm_pkg::MODE_SLEEP && !st_ff.wdt_en |=> !slow_osc_run_o;
  endproperty
  a_slow_sleep: assert property (p_slow_sleep) else $error("slow osc kept in sleep");

  c_sleep: cover property (@(posedge clk_i) st_ff.mode == scm_pkg::MODE_SLEEP);
  c_wake: cover property (@(posedge clk_i) halted ##1 !halted);
  c_slow_sel: cover property (@(posedge clk_i) st_ff.sel_act == scm_pkg::SEL_SLOW);
  c_stable: cover property (@(posedge clk_i) $rose(st_ff.fast_stable));

endmodule

`default_nettype wire

/* scm_core_model.sv */
/*
  core-side model: one-cycle halt requests and a later wake.
  assumes one clock and a sync active-high reset.
*/
`default_nettype none
module scm_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // requests from the bench
  input wire logic halt_go_i,
  input wire logic [7:0] wake_dly_i,
  // toward the controller
  output logic halt_o,
  output logic wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic wait_ff;
  // wake only after a programmable stay, so halted checks have time
  always_ff @(posedge clk_i) begin
    halt_o <= 1'b0;
    wake_o <= 1'b0;
    if (reset_i) begin
      wait_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (halt_go_i && !wait_ff) begin
      halt_o <= 1'b1;
      wait_ff <= 1'b1;
      cnt_ff <= wake_dly_i;
    end else if (wait_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h00) begin
        wake_o <= 1'b1;
        wait_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
/*
  self-checking bench for the clock and mode controller.
  assumes scm_pkg and scm_core_model are compiled first.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic halt_go = 1'b0;
  logic wdt_timeout_i = 1'b0;
  logic [7:0] wake_dly = 8'h28;
  logic halt_i, wake_i, sys_clk_en_o, fast_osc_run_o, slow_osc_run_o;
  logic wdt_clear_o, cpu_stopped_o, seen;
  logic [7:0] rdata_o, d, v;
  logic [2:0] mode_o;
  logic [31:0] seed = 32'h0000_c84d;
  int num_errors = 0;
  int compares = 0;
  int n;
  scm_sysclk_mode_control u_scm_sysclk_mode_control (.clk_i, .reset_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .halt_i, .wake_i, .wdt_timeout_i,
    .sys_clk_en_o, .fast_osc_run_o, .slow_osc_run_o, .wdt_clear_o,
    .cpu_stopped_o, .mode_o);
  scm_core_model u_scm_core_model (.clk_i, .reset_i, .halt_go_i(halt_go),
    .wake_dly_i(wake_dly), .halt_o(halt_i), .wake_o(wake_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_mode(input logic [1:0] k);
    case (k)
      2'b00: return 8'(scm_pkg::MODE_SLEEP);
      2'b01: return 8'(scm_pkg::MODE_IDLE_SLOW_ONLY);
      2'b11: return 8'(scm_pkg::MODE_IDLE_BOTH_CLOCKS);
      default: return 8'(scm_pkg::MODE_IDLE_FAST_ONLY);
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= x;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic count_en(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      #1 n += int'(sys_clk_en_o);
    end
  endtask
  // halt entry can take a few edges through the core model
  task automatic do_halt();
    seen = 1'b0;
    @(posedge clk_i);
    halt_go <= 1'b1;
    @(posedge clk_i);
    halt_go <= 1'b0;
    for (int i = 0; i < 8 && cpu_stopped_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1 seen |= (wdt_clear_o === 1'b1);
    end
    if (cpu_stopped_o !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic final_report();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(scm_pkg::OFF_SYS_CLK_CTRL);
    check("clk ctrl reset", 8'h00, d);
    @(posedge clk_i);
    #1 check("rdata idle", 8'h00, rdata_o);
    rd(scm_pkg::OFF_FAST_OSC_CTRL);
    check("fast ctrl reset", 8'h01, d);
    rd(4'hf);
    check("unmapped", 8'h00, d);
    rd(scm_pkg::OFF_WDT_CTRL);
    check("wdt ctrl reset", 8'h01, d);
    repeat (260) @(posedge clk_i);
    rd(scm_pkg::OFF_FAST_OSC_CTRL);
    check("stable", 8'h03, d);
    wr(scm_pkg::OFF_FAST_OSC_CTRL, 8'hff);
    wr(scm_pkg::OFF_FAST_OSC_CTRL, 8'h00);
    rd(scm_pkg::OFF_FAST_OSC_CTRL);
    check("fast off", 8'h00, d);
    wr(scm_pkg::OFF_FAST_OSC_CTRL, 8'h01);
    rd(scm_pkg::OFF_FAST_OSC_CTRL);
    check("restart", 8'h01, d);
    repeat (260) @(posedge clk_i);
    rd(scm_pkg::OFF_FAST_OSC_CTRL);
    check("restable", 8'h03, d);
    for (int i = 0; i < 6; i++) begin
      v = 8'(xs());
      wr(scm_pkg::OFF_SYS_CLK_CTRL, v);
      rd(scm_pkg::OFF_SYS_CLK_CTRL);
      check("clk ctrl", v & 8'he3, d);
    end
    // slow code last, then back to fast
    for (int c = 0; c < 9; c++) begin
      wr(scm_pkg::OFF_SYS_CLK_CTRL, {3'(c % 8), 5'h00});
      repeat (80) @(posedge clk_i);
      count_en(128);
      check("enables", 8'(c % 8 < 7 ? 128 >> (c % 8) : 128), 8'(n));
    end
    for (int k = 0; k < 4; k++) begin
      v = {3'(xs() % 7), 3'h0, 2'(k)};
      wr(scm_pkg::OFF_STATUS, 8'h00);
      wr(scm_pkg::OFF_SYS_CLK_CTRL, v);
      // watchdog off in the first two halts so sleep may drop the slow source
      wr(scm_pkg::OFF_WDT_CTRL, 8'(k >= 2));
      @(posedge clk_i);
      wdt_timeout_i <= 1'b1;
      @(posedge clk_i);
      wdt_timeout_i <= 1'b0;
      rd(scm_pkg::OFF_STATUS);
      check("timeout set", 8'h02, d);
      do_halt();
      check("stopped", 8'h01, 8'(cpu_stopped_o));
      check("mode", exp_mode(2'(k)), 8'(mode_o));
      check("wdt clear", 8'h01, 8'(seen));
      @(posedge clk_i);
      #1 check("cpu clock", 8'h00, 8'(sys_clk_en_o));
      check("fast run", 8'(k[1]), 8'(fast_osc_run_o));
      check("slow run", 8'(k[0] | (k >= 2)), 8'(slow_osc_run_o));
      rd(scm_pkg::OFF_STATUS);
      check("status", 8'h01, d);
      wr(scm_pkg::OFF_SYS_CLK_CTRL, ~v);
      for (int i = 0; i < 100 && cpu_stopped_o !== 1'b0; i++) begin
        @(posedge clk_i);
        #1;
      end
      if (cpu_stopped_o !== 1'b0) begin
        num_errors++;
        final_report();
      end
      check("woken", 8'(scm_pkg::MODE_RUN), 8'(mode_o));
      rd(scm_pkg::OFF_SYS_CLK_CTRL);
      check("kept", v, d);
    end
    final_report();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
